// file: rtl/pcr_pkg.sv
/*
  Shared constants for the power, clock and reset control block: register
  offsets, field positions, strap codes, reference selections and clock rates.
  Assumes a 32-bit register port with byte offsets and one 10 MHz clock.
*/
package pcr_pkg;

  localparam int unsigned ADDR_W = 8;
  localparam int unsigned DATA_W = 32;
  localparam int unsigned NPORT  = 4;
  localparam int unsigned MODE_W = 5;

  localparam logic [ADDR_W-1:0] OFS_CTRL     = 8'h00;
  localparam logic [ADDR_W-1:0] OFS_STRAP_LO = 8'h04;
  localparam logic [ADDR_W-1:0] OFS_STRAP_HI = 8'h08;
  localparam logic [ADDR_W-1:0] OFS_RESET    = 8'h0C;
  localparam logic [ADDR_W-1:0] OFS_STATUS   = 8'h10;

  localparam int unsigned CTRL_PD     = 0;
  localparam int unsigned CTRL_PLLOFF = 1;
  localparam int unsigned CTRL_XTALN  = 2;

  localparam int unsigned SLO_DIS  = 0;
  localparam int unsigned SLO_EN   = 1;
  localparam int unsigned SLO_MODE = 2;
  localparam int unsigned SHI_W    = 8;
  localparam logic [SHI_W-1:0] SHI_RESET = 8'h00;

  localparam int unsigned RST_CHIP_HARD = 0;
  localparam int unsigned RST_CHIP_SOFT = 1;
  localparam int unsigned RST_SL_HARD   = 2;
  localparam int unsigned RST_SL_SOFT   = 3;
  localparam int unsigned RST_SER_TX    = 4;
  localparam int unsigned RST_SER_RX    = 5;
  localparam int unsigned RST_PORT_HARD = 8;
  localparam int unsigned RST_PORT_SOFT = 12;
  localparam int unsigned RST_CORE_HARD = 16;
  localparam int unsigned RST_CORE_SOFT = 20;

  localparam int unsigned ST_PD      = 0;
  localparam int unsigned ST_PLL_OFF = 1;
  localparam int unsigned ST_SYSPLL  = 2;
  localparam int unsigned ST_REF     = 3;
  localparam int unsigned ST_COMA    = 5;
  localparam int unsigned ST_GATED   = 6;

  localparam logic [MODE_W-1:0] MODE_SPD_PLL_OFF = 5'h09;
  localparam logic [MODE_W-1:0] MODE_SPD_PLL_ON  = 5'h08;

  typedef enum logic [1:0] {
    REF_XTAL = 2'h0,
    REF_SE   = 2'h1,
    REF_DIFF = 2'h2,
    REF_RSVD = 2'h3
  } pcr_ref_e;

  typedef enum logic [1:0] {
    PS_RUN      = 2'b00,
    PS_SPD      = 2'b01,
    PS_SPD_NPLL = 2'b10,
    PS_XTAL_OFF = 2'b11
  } pcr_pstate_e;

  localparam int unsigned REF_LOW_MHZ  = 25;
  localparam int unsigned REF_DIFF_MHZ = 125;
  localparam int unsigned SYS_HI_MHZ   = 250;
  localparam int unsigned SL_MHZ       = 250;
  localparam logic [3:0] SYS_DIV_LOW  = 4'(SYS_HI_MHZ / REF_LOW_MHZ);
  localparam logic [3:0] SYS_DIV_DIFF = 4'(SYS_HI_MHZ / REF_DIFF_MHZ);
  localparam logic [3:0] SL_DIV_LOW   = 4'(SL_MHZ / REF_LOW_MHZ);
  localparam logic [3:0] SL_DIV_DIFF  = 4'(SL_MHZ / REF_DIFF_MHZ);

endpackage

// file: rtl/pcr_sync_if.sv
/*
  Carrier for synchronised reset and pin levels between the synchroniser
  and the control logic. Assumes both ends run on ref_clk.
*/
`timescale 1ns/1ns
`default_nettype none
interface pcr_sync_if;
  import pcr_pkg::*;
  logic              rst_n;
  logic [MODE_W-1:0] mode;
  logic [1:0]        ref_sel;
  logic              coma;
  modport src (output rst_n, output mode, output ref_sel, output coma);
  modport dst (input rst_n, input mode, input ref_sel, input coma);
endinterface
`default_nettype wire

// file: rtl/pcr_sync.sv
/*
  Reset release synchroniser and two-stage synchronisers for strap,
  reference-select and suspend pins. Assumes straps are stable around the
  release of the reset pin.
*/
`timescale 1ns/1ns
`default_nettype none
module pcr_sync
  import pcr_pkg::*;
(
  // Clock and reset pin
  input  wire logic              ref_clk,
  input  wire logic              rstn,
  // Pins
  input  wire logic [MODE_W-1:0] mode_pin,
  input  wire logic [1:0]        ref_sel_pin,
  input  wire logic              coma_pin,
  // Synchronised side
  pcr_sync_if.src                sif
);

  logic              rst_meta;
  logic              rst_hold;
  logic [MODE_W-1:0] mode_meta;
  logic [1:0]        ref_meta;
  logic              coma_meta;

  // Assertion acts at once; release waits two edges to avoid metastable exit.
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      rst_meta <= 1'b0;
      rst_hold <= 1'b0;
    end else begin
      rst_meta <= 1'b1;
      rst_hold <= rst_meta;
    end
  end

  // Pin levels run without reset so they are settled when reset lifts.
  always_ff @(posedge ref_clk) begin
    mode_meta   <= mode_pin;
    sif.mode    <= mode_meta;
    ref_meta    <= ref_sel_pin;
    sif.ref_sel <= ref_meta;
    coma_meta   <= coma_pin;
    sif.coma    <= coma_meta;
  end

  assign sif.rst_n = rst_hold;

endmodule
`default_nettype wire

// file: rtl/pcr_top.sv
/*
  Power-down, clock-source and reset control. Holds the power state machine,
  strap override registers, PLL reference choice and software reset pulses.
  Assumes a single 10 MHz ref_clk from the crystal domain and a register
  master that reads data one cycle after the read strobe.
*/
// The register offsets and the address-and-strobe port were decided locally.
`timescale 1ns/1ns
`default_nettype none
// Notes on behaviour
// - Power-down bit write one enters, zero leaves.
// - PLL-off set beforehand keeps PLL off throughout.
// - Strap 01001 starts powered down, PLL off.
// - Exit or PLL-off clear then forces device reset.
// - Defaults come from strap override registers.
// - Override mode bits set re-enter power-down.
// - Crystal-disable after PLL-off power-down stops crystal.
// - Only reset pin recovers stopped crystal.
// - Suspend input never touches either PLL.
// - Two-bit pins choose both PLL references.
// - System PLL makes 250 MHz from 25 or 125 MHz.
// - System reference: crystal, single-ended, differential.
// - Serial PLL makes 250 MHz from either.
// - Chip soft reset spares PHY cores.
// - Chip hard reset starts core calibration.
// - Serial-link hard, soft, transmit, receive resets.
// - Port resets spare that port's PHY core.
// - Leave reset on pin low-to-high.
// - Power-down gates fast clocks, registers keep working until crystal stops.
module pcr_top
  import pcr_pkg::*;
(
  // Clock and reset
  input  wire logic              ref_clk,
  input  wire logic              rstn,
  // Pins
  input  wire logic [MODE_W-1:0] mode_pin,
  input  wire logic [1:0]        ref_sel_pin,
  input  wire logic              coma_pin,
  // Register port
  input  wire logic [ADDR_W-1:0] addr,
  input  wire logic [DATA_W-1:0] wdata,
  input  wire logic              wr,
  input  wire logic              rd,
  output logic      [DATA_W-1:0] rdata,
  // Clock control
  output logic                   sys_pll_en,
  output logic                   serial_link_pll_en,
  output logic                   crystal_osc_en,
  output logic                   hs_clk_gate,
  output logic      [1:0]        sys_pll_ref,
  output logic                   serial_link_pll_ref_diff,
  output logic      [3:0]        sys_pll_fb_div,
  output logic      [3:0]        serial_link_pll_fb_div,
  // Reset outputs
  output logic                   chip_logic_rst,
  output logic      [NPORT-1:0]  gigabit_phy_core_rst,
  output logic                   gigabit_phy_core_calib,
  output logic                   serial_link_rst,
  output logic                   serializer_tx_rst,
  output logic                   serializer_rx_rst,
  output logic      [NPORT-1:0]  port_rst,
  output logic                   in_power_down
);

  pcr_sync_if sif ();

  pcr_sync u_sync (
    .ref_clk     (ref_clk),
    .rstn        (rstn),
    .mode_pin    (mode_pin),
    .ref_sel_pin (ref_sel_pin),
    .coma_pin    (coma_pin),
    .sif         (sif.src)
  );

  logic              rst_n_int;
  logic              started;
  pcr_pstate_e       state;
  pcr_pstate_e       next_state;
  logic              pll_off;
  logic              crystal_enable_n;
  logic              pll_dis_mode;
  logic              pll_en_mode;
  logic [MODE_W-1:0] mode_sampled;
  logic [SHI_W-1:0]  strap_hi;
  logic              dev_rst;
  logic              dev_req;
  logic              wr_ctrl;
  logic              wr_slo;
  logic              wr_shi;
  logic              wr_rst;
  logic              bus_live;
  pcr_ref_e          ref_code;

  assign rst_n_int = sif.rst_n;

  // Power state that strap override bits call for after any device reset.
  function automatic pcr_pstate_e strap_state(input logic dis, input logic en);
    pcr_pstate_e s;
    s = PS_RUN;
    if (dis) begin
      s = PS_SPD_NPLL;
    end else if (en) begin
      s = PS_SPD;
    end
    return s;
  endfunction

  // Match of a register offset, used by every write and the read decode.
  function automatic logic hit(input logic [ADDR_W-1:0] a,
                               input logic [ADDR_W-1:0] ofs);
    return a == ofs;
  endfunction

  // Chip-wide reset bits, shared by the chip, link, serializer and port reset outputs below.
  function automatic logic chip_hit(input logic [DATA_W-1:0] w);
    return w[RST_CHIP_HARD] || w[RST_CHIP_SOFT];
  endfunction

  // Serial-link reset bits; the chip resets cover the link as well.
  function automatic logic link_hit(input logic [DATA_W-1:0] w);
    return chip_hit(w) || w[RST_SL_HARD] || w[RST_SL_SOFT];
  endfunction

  // Both PLLs run unless the PLL is held off or the crystal is stopped.
  function automatic logic pll_runs(input pcr_pstate_e s);
    return (s == PS_RUN) || (s == PS_SPD);
  endfunction

  // Once the crystal stops, management access is dead until the pin reset.
  assign bus_live = (state != PS_XTAL_OFF);
  assign wr_ctrl  = wr && bus_live && hit(addr, OFS_CTRL);
  assign wr_slo   = wr && bus_live && hit(addr, OFS_STRAP_LO);
  assign wr_shi   = wr && bus_live && hit(addr, OFS_STRAP_HI);
  assign wr_rst   = wr && bus_live && hit(addr, OFS_RESET);

  // The state machine requests a device reset only while the PLL is held off in power-down; a chip hard reset write also requests one.
  always_comb begin
    dev_req    = 1'b0;
    next_state = state;
    case (state)
      PS_RUN: begin
        if (wr_ctrl && wdata[CTRL_PD]) begin
          next_state = pll_off ? PS_SPD_NPLL : PS_SPD;
        end
      end
      PS_SPD: begin
        if (wr_ctrl && !wdata[CTRL_PD]) begin
          next_state = PS_RUN;
        end
      end
      PS_SPD_NPLL: begin
        if (wr_ctrl && (!wdata[CTRL_PD] || !wdata[CTRL_PLLOFF])) begin
          dev_req = 1'b1;
        end else if (wr_ctrl && wdata[CTRL_XTALN]) begin
          next_state = PS_XTAL_OFF;
        end
      end
      PS_XTAL_OFF: begin
        next_state = PS_XTAL_OFF;
      end
      default: begin
        next_state = PS_RUN;
      end
    endcase
  end

  // First cycle after release catches the straps; the reset pin is the
  // only thing that reloads the override registers from the pins.
  always_ff @(posedge ref_clk or negedge rst_n_int) begin
    if (!rst_n_int) begin
      started      <= 1'b0;
      mode_sampled <= '0;
      pll_dis_mode <= 1'b0;
      pll_en_mode  <= 1'b0;
      strap_hi     <= SHI_RESET;
    end else if (!started) begin
      started      <= 1'b1;
      mode_sampled <= sif.mode;
      pll_dis_mode <= (sif.mode == MODE_SPD_PLL_OFF);
      pll_en_mode  <= (sif.mode == MODE_SPD_PLL_ON);
    end else begin
      if (wr_slo) begin
        pll_dis_mode <= wdata[SLO_DIS];
        pll_en_mode  <= wdata[SLO_EN];
      end
      if (wr_shi) begin
        strap_hi <= wdata[SHI_W-1:0];
      end
    end
  end

  // Device reset takes one cycle and then reloads from the override bits.
  always_ff @(posedge ref_clk or negedge rst_n_int) begin
    if (!rst_n_int) begin
      dev_rst <= 1'b0;
    end else begin
      dev_rst <= dev_req || (wr_rst && wdata[RST_CHIP_HARD]);
    end
  end

  // Pin-reset straps load first; a device reset then beats any pending write.
  always_ff @(posedge ref_clk or negedge rst_n_int) begin
    if (!rst_n_int) begin
      state <= PS_RUN;
    end else if (!started) begin
      state <= strap_state(sif.mode == MODE_SPD_PLL_OFF,
                           sif.mode == MODE_SPD_PLL_ON);
    end else if (dev_rst) begin
      state <= strap_state(pll_dis_mode, pll_en_mode);
    end else begin
      state <= next_state;
    end
  end

  // Control bits return to defaults on device reset, drawn from overrides.
  always_ff @(posedge ref_clk or negedge rst_n_int) begin
    if (!rst_n_int) begin
      pll_off          <= 1'b0;
      crystal_enable_n <= 1'b0;
    end else if (!started) begin
      pll_off          <= (sif.mode == MODE_SPD_PLL_OFF);
      crystal_enable_n <= 1'b0;
    end else if (dev_rst) begin
      pll_off          <= pll_dis_mode;
      crystal_enable_n <= 1'b0;
    end else if (wr_ctrl && !dev_req) begin
      pll_off          <= wdata[CTRL_PLLOFF];
      crystal_enable_n <= wdata[CTRL_XTALN];
    end
  end

  // Reference choice is shared by both PLLs; the reserved code falls back
  // to the crystal so the PLLs never lose a reference.
  always_comb begin
    ref_code = pcr_ref_e'(sif.ref_sel);
    if (ref_code == REF_RSVD) begin
      ref_code = REF_XTAL;
    end
  end

  // The suspend pin only shows in status; PLL enables ignore it.
  always_ff @(posedge ref_clk or negedge rst_n_int) begin
    if (!rst_n_int) begin
      sys_pll_en               <= 1'b0;
      serial_link_pll_en       <= 1'b0;
      crystal_osc_en           <= 1'b1;
      hs_clk_gate              <= 1'b1;
      sys_pll_ref              <= REF_XTAL;
      serial_link_pll_ref_diff <= 1'b0;
      sys_pll_fb_div           <= SYS_DIV_LOW;
      serial_link_pll_fb_div   <= SL_DIV_LOW;
      in_power_down            <= 1'b0;
    end else begin
      sys_pll_en         <= pll_runs(state);
      serial_link_pll_en <= pll_runs(state);
      crystal_osc_en     <= (state != PS_XTAL_OFF);
      hs_clk_gate        <= (state != PS_RUN);
      in_power_down      <= (state != PS_RUN);
      sys_pll_ref        <= ref_code;
      if (ref_code == REF_DIFF) begin
        sys_pll_fb_div           <= SYS_DIV_DIFF;
        serial_link_pll_fb_div   <= SL_DIV_DIFF;
        serial_link_pll_ref_diff <= 1'b1;
      end else begin
        sys_pll_fb_div           <= SYS_DIV_LOW;
        serial_link_pll_fb_div   <= SL_DIV_LOW;
        serial_link_pll_ref_diff <= 1'b0;
      end
    end
  end

  // Software resets are one-cycle pulses, two cycles for chip hard reset; a device reset hits everything.
  // While the pin reset is held, all reset outputs stay asserted.
  always_ff @(posedge ref_clk or negedge rst_n_int) begin
    if (!rst_n_int) begin
      chip_logic_rst         <= 1'b1;
      gigabit_phy_core_rst   <= '1;
      gigabit_phy_core_calib <= 1'b0;
      serial_link_rst        <= 1'b1;
      serializer_tx_rst      <= 1'b1;
      serializer_rx_rst      <= 1'b1;
      port_rst               <= '1;
    end else begin
      chip_logic_rst <= dev_rst
                     || (wr_rst && chip_hit(wdata));
      gigabit_phy_core_calib <= !started || (wr_rst && wdata[RST_CHIP_HARD]);
      serial_link_rst <= dev_rst
                      || (wr_rst && link_hit(wdata));
      serializer_tx_rst <= dev_rst
                        || (wr_rst && (link_hit(wdata) || wdata[RST_SER_TX]));
      serializer_rx_rst <= dev_rst
                        || (wr_rst && (link_hit(wdata) || wdata[RST_SER_RX]));
      for (int i = 0; i < NPORT; i++) begin
        gigabit_phy_core_rst[i] <= dev_rst
          || (wr_rst && (wdata[RST_CHIP_HARD]
          || wdata[RST_CORE_HARD+i] || wdata[RST_CORE_SOFT+i]));
        port_rst[i] <= dev_rst
          || (wr_rst && (chip_hit(wdata)
          || wdata[RST_PORT_HARD+i] || wdata[RST_PORT_SOFT+i]));
      end
    end
  end

  // Read data stand for exactly one cycle; unmapped offsets read zero.
  always_ff @(posedge ref_clk or negedge rst_n_int) begin
    if (!rst_n_int) begin
      rdata <= '0;
    end else begin
      rdata <= '0;
      if (rd && bus_live) begin
        if (hit(addr, OFS_CTRL)) begin
          rdata[CTRL_PD]     <= (state != PS_RUN);
          rdata[CTRL_PLLOFF] <= pll_off;
          rdata[CTRL_XTALN]  <= crystal_enable_n;
        end else if (hit(addr, OFS_STRAP_LO)) begin
          rdata[SLO_DIS] <= pll_dis_mode;
          rdata[SLO_EN]  <= pll_en_mode;
          rdata[SLO_MODE+MODE_W-1:SLO_MODE] <= mode_sampled;
        end else if (hit(addr, OFS_STRAP_HI)) begin
          rdata[SHI_W-1:0] <= strap_hi;
        end else if (hit(addr, OFS_STATUS)) begin
          rdata[ST_PD]          <= (state != PS_RUN);
          rdata[ST_PLL_OFF]     <= (state == PS_SPD_NPLL);
          rdata[ST_SYSPLL]      <= sys_pll_en;
          rdata[ST_REF+1:ST_REF] <= sys_pll_ref;
          rdata[ST_COMA]        <= sif.coma;
          rdata[ST_GATED]       <= hs_clk_gate;
        end
      end
    end
  end

endmodule
`default_nettype wire

// file: tb/pcr_top_asserts.sv
/*
  Port checker for pcr_top: power-down entry, device reset, reset pulses.
  Assumes one ref_clk domain and binding to pcr_top from the bench.
*/
`timescale 1ns/1ns
`default_nettype none
module pcr_top_chk
  import pcr_pkg::*;
(
  // Clock and reset
  input wire logic              ref_clk,
  input wire logic              rstn,
  // Register port
  input wire logic [ADDR_W-1:0] addr,
  input wire logic [DATA_W-1:0] wdata,
  input wire logic              wr,
  // Clock control
  input wire logic              sys_pll_en,
  input wire logic              crystal_osc_en,
  input wire logic              hs_clk_gate,
  input wire logic              serial_link_pll_ref_diff,
  input wire logic [1:0]        sys_pll_ref,
  input wire logic [3:0]        sys_pll_fb_div,
  // Reset outputs
  input wire logic              chip_logic_rst,
  input wire logic [NPORT-1:0]  gigabit_phy_core_rst,
  input wire logic              gigabit_phy_core_calib,
  input wire logic              serial_link_rst,
  input wire logic [NPORT-1:0]  port_rst,
  input wire logic              in_power_down
);
  // Outputs still carry reset values for a few edges after release.
  logic [2:0] up_cnt;
  wire logic  ready = (up_cnt == 3'h7);
  wire logic  rst_wr = wr && addr == OFS_RESET && crystal_osc_en;
  logic       clk_seen;
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      up_cnt <= 3'h0;
    end else if (!ready) begin
      up_cnt <= up_cnt + 3'h1;
    end
  end
  // The pin check waits one edge so power-up unknowns are not judged.
  always_ff @(posedge ref_clk) begin
    clk_seen <= 1'b1;
  end
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rstn || !ready);
  sequence s_ctrl_exit;
    crystal_osc_en && in_power_down && !sys_pll_en && wr && addr == OFS_CTRL
      && !(wdata[CTRL_PD] && wdata[CTRL_PLLOFF]);
  endsequence
  sequence s_dev_rst;
    chip_logic_rst && serial_link_rst && port_rst == 4'hf;
  endsequence
  AST_DEV_RST: assert property (s_ctrl_exit |-> ##2 s_dev_rst)
    else $error("no device reset after power-down exit");
  AST_PD_ENTER: assert property (!in_power_down && crystal_osc_en && wr
    && addr == OFS_CTRL && wdata[CTRL_PD] |-> ##2 in_power_down)
    else $error("power-down not entered");
  AST_GATE: assert property (in_power_down |-> hs_clk_gate)
    else $error("fast clocks not gated in power-down");
  AST_FB_DIV: assert property (sys_pll_fb_div == ((sys_pll_ref == 2'h2) ? 4'h2 : 4'ha)
    && serial_link_pll_ref_diff == (sys_pll_ref == 2'h2))
    else $error("feedback divider does not match reference");
  AST_SOFT: assert property (rst_wr && wdata[1:0] == 2'b10 && wdata[23:16] == 8'h00
    |=> chip_logic_rst && gigabit_phy_core_rst == 4'h0)
    else $error("chip soft reset wrong");
  AST_CALIB: assert property (rst_wr && wdata[RST_CHIP_HARD] |-> ##[1:2] gigabit_phy_core_calib)
    else $error("calibration not started");
  AST_PORT: assert property (rst_wr && wdata[1:0] == 2'b00
    |=> port_rst == $past(wdata[11:8] | wdata[15:12])
    && gigabit_phy_core_rst == $past(wdata[19:16] | wdata[23:20]))
    else $error("port reset wrong");
  AST_XTAL: assert property (!crystal_osc_en |=> !crystal_osc_en)
    else $error("crystal restarted without pin reset");
  AST_PIN_RST: assert property (disable iff (1'b0) !rstn && clk_seen
    |-> chip_logic_rst && !sys_pll_en)
    else $error("reset pin not applied at once");
endmodule
`default_nettype wire

// file: tb/pcr_board.sv
/*
  Board side: reset pin and operating-mode straps.
  Assumes the bench requests pin reset and sets straps while reset is held.
*/
`timescale 1ns/1ns
`default_nettype none
module pcr_board
  import pcr_pkg::*;
(
  // Clock
  input  wire logic              ref_clk,
  // Bench requests
  input  wire logic              pin_rst_req,
  input  wire logic [MODE_W-1:0] strap,
  // Pins
  output var  logic              rstn,
  output var  logic [MODE_W-1:0] mode_pin
);
  logic [3:0] hold_cnt;
  initial begin
    rstn = 1'b0;
    mode_pin = 5'h00;
    hold_cnt = 4'h0;
  end
  always @(posedge ref_clk) begin
    rstn <= !pin_rst_req;
  end
  // Straps hold through release, then the shared pins toggle so a late resample shows.
  always @(posedge ref_clk) begin
    if (pin_rst_req) begin
      hold_cnt <= 4'h0;
      mode_pin <= strap;
    end else if (hold_cnt != 4'hf) begin
      hold_cnt <= hold_cnt + 4'h1;
    end else begin
      mode_pin <= ~mode_pin;
    end
  end
endmodule
`default_nettype wire

// file: tb/pcr_top_test.sv
/*
  Self-checking bench for pcr_top: power sequence, references, resets.
  Assumes the board model drives the reset pin and straps.
*/
`timescale 1ns/1ns
`default_nettype none
module pcr_top_test;
  import pcr_pkg::*;
  logic ref_clk = 1'b0;
  logic pin_rst_req = 1'b1;
  logic [4:0] strap = 5'h03;
  logic rstn;
  logic [4:0] mode_pin;
  logic [1:0] ref_sel_pin = 2'h0;
  logic coma_pin = 1'b0;
  logic [7:0] addr = 8'h00;
  logic [31:0] wdata = 32'h0000_0000;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic [31:0] rdata;
  logic sys_pll_en, serial_link_pll_en, crystal_osc_en, hs_clk_gate, ref_diff;
  logic [1:0] sys_pll_ref;
  logic [3:0] sys_div, sl_div, core_rst, port_rst;
  logic chip_logic_rst, calib, serial_link_rst, ser_tx_rst, ser_rx_rst, in_power_down;
  logic [31:0] lfsr = 32'hd22a_8dac;
  logic [31:0] d;
  int sl_bit[3] = '{RST_SL_HARD, RST_SER_TX, RST_SER_RX};
  int mismatches = 0;
  int compares = 0;
  wire logic [2:0] sl_vec = {ser_rx_rst, ser_tx_rst, serial_link_rst};
  always #50 ref_clk = ~ref_clk;
  pcr_board pcr_board_i (.ref_clk, .pin_rst_req, .strap, .rstn, .mode_pin);
  pcr_top pcr_top_i (.ref_clk, .rstn, .mode_pin, .ref_sel_pin, .coma_pin, .addr, .wdata,
    .wr, .rd, .rdata, .sys_pll_en, .serial_link_pll_en, .crystal_osc_en, .hs_clk_gate,
    .sys_pll_ref, .serial_link_pll_ref_diff(ref_diff), .sys_pll_fb_div(sys_div),
    .serial_link_pll_fb_div(sl_div), .chip_logic_rst, .gigabit_phy_core_rst(core_rst),
    .gigabit_phy_core_calib(calib), .serial_link_rst, .serializer_tx_rst(ser_tx_rst),
    .serializer_rx_rst(ser_rx_rst), .port_rst, .in_power_down);
  function automatic logic [31:0] next_rand(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  // Feedback ratio is 250 MHz over the chosen reference; code 3 falls back to crystal.
  function automatic logic [31:0] exp_div(input logic [1:0] sel);
    return (sel == 2'h2) ? 32'h0000_0002 : 32'h0000_000a;
  endfunction
  task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      mismatches++;
      $display("ERROR %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge ref_clk);
    #1;
  endtask
  task automatic wr_reg(input logic [7:0] a, input logic [31:0] v);
    @(posedge ref_clk);
    addr <= a;
    wdata <= v;
    wr <= 1'b1;
    @(posedge ref_clk);
    wr <= 1'b0;
  endtask
  task automatic rd_reg(input logic [7:0] a, input logic [31:0] exp);
    @(posedge ref_clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge ref_clk);
    rd <= 1'b0;
    #1 cmp(rdata, exp);
  endtask
  task automatic pin_reset(input logic [4:0] s);
    pin_rst_req <= 1'b1;
    strap <= s;
    tick(20);
    pin_rst_req <= 1'b0;
    tick(8);
  endtask
  task automatic finish_test();
    if (mismatches == 0 && compares > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  initial begin
    #2_000_000;
    mismatches++;
    finish_test();
  end
  initial begin
    pin_reset(5'h03);
    cmp(32'(in_power_down), 32'h0);
    rd_reg(OFS_STRAP_LO, 32'h0000_000c);
    rd_reg(8'h20, 32'h0);
    wr_reg(OFS_STRAP_HI, 32'h0000_00a5);
    rd_reg(OFS_STRAP_HI, 32'h0000_00a5);
    for (int i = 0; i < 4; i++) begin
      ref_sel_pin <= 2'(i);
      tick(6);
      cmp(32'(sys_div), exp_div(2'(i)));
      cmp(32'(sl_div), exp_div(2'(i)));
      cmp(32'(ref_diff), 32'(i == 2));
      cmp(32'(sys_pll_ref), (i == 3) ? 32'h0 : 32'(i));
    end
    coma_pin <= 1'b1;
    tick(6);
    cmp(32'({sys_pll_en, serial_link_pll_en}), 32'h3);
    rd_reg(OFS_STATUS, 32'h0000_0024);
    coma_pin <= 1'b0;
    wr_reg(OFS_CTRL, 32'h1);
    tick(2);
    cmp(32'({in_power_down, hs_clk_gate, sys_pll_en}), 32'h7);
    rd_reg(OFS_CTRL, 32'h1);
    wr_reg(OFS_CTRL, 32'h0);
    tick(2);
    cmp(32'({in_power_down, hs_clk_gate}), 32'h0);
    for (int k = 0; k < 2; k++) begin
      wr_reg(OFS_STRAP_LO, k ? 32'h2 : 32'h0);
      wr_reg(OFS_CTRL, 32'h2);
      wr_reg(OFS_CTRL, 32'h3);
      tick(2);
      cmp(32'({in_power_down, sys_pll_en}), 32'h2);
      wr_reg(OFS_CTRL, 32'h2);
      tick(4);
      cmp(32'({in_power_down, sys_pll_en}), k ? 32'h3 : 32'h1);
      rd_reg(OFS_CTRL, k ? 32'h1 : 32'h0);
    end
    wr_reg(OFS_STRAP_LO, 32'h0);
    wr_reg(OFS_CTRL, 32'h0);
    tick(2);
    cmp(32'(in_power_down), 32'h0);
    for (int i = 0; i < 8; i++) begin
      lfsr = next_rand(lfsr);
      d = lfsr & 32'h00ff_ff00;
      wr_reg(OFS_RESET, d);
      #1;
      cmp(32'(port_rst), 32'(d[11:8] | d[15:12]));
      cmp(32'(core_rst), 32'(d[19:16] | d[23:20]));
    end
    for (int j = 0; j < 3; j++) begin
      wr_reg(OFS_RESET, 32'h1 << sl_bit[j]);
      #1;
      cmp(32'(sl_vec), (j == 0) ? 32'h7 : 32'h1 << j);
    end
    wr_reg(OFS_RESET, 32'h2);
    #1;
    cmp(32'({chip_logic_rst, core_rst}), 32'h10);
    rd_reg(OFS_RESET, 32'h0);
    wr_reg(OFS_RESET, 32'h1);
    #1;
    cmp(32'(chip_logic_rst), 32'h1);
    cmp(32'(calib), 32'h1);
    tick(4);
    pin_reset(5'h09);
    cmp(32'({in_power_down, sys_pll_en}), 32'h2);
    rd_reg(OFS_STRAP_LO, 32'h0000_0025);
    wr_reg(OFS_CTRL, 32'h7);
    tick(2);
    cmp(32'(crystal_osc_en), 32'h0);
    wr_reg(OFS_CTRL, 32'h0);
    tick(4);
    cmp(32'({in_power_down, crystal_osc_en}), 32'h2);
    rd_reg(OFS_CTRL, 32'h0);
    pin_reset(5'h00);
    cmp(32'({in_power_down, crystal_osc_en}), 32'h1);
    finish_test();
  end
endmodule
bind pcr_top pcr_top_chk pcr_top_chk_i (.ref_clk, .rstn, .addr, .wdata, .wr, .sys_pll_en,
  .crystal_osc_en, .hs_clk_gate, .serial_link_pll_ref_diff, .sys_pll_ref, .sys_pll_fb_div,
  .chip_logic_rst, .gigabit_phy_core_rst, .gigabit_phy_core_calib, .serial_link_rst,
  .port_rst, .in_power_down);
`default_nettype wire
